// ===== logic/sbc_pkg.sv
// Constants, types and register layout shared by the mode and watchdog controller.
package sbc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register addresses on the command port.
	localparam logic [3:0] ADDR_MODE_CTRL   = 4'h1;
	localparam logic [3:0] ADDR_WD_TIMING   = 4'h2;
	localparam logic [3:0] ADDR_LOW_POWER   = 4'h3;
	localparam logic [3:0] ADDR_STATUS      = 4'h8;

	////////////////////////////////////////////////////////////////////////////////
	// Mode-control data codes; bit 3 is ignored for the mode selections.
	localparam logic [3:0] MCR_DEBUG_TOGGLE = 4'h0;
	localparam logic [2:0] MCR_SEL_NORMAL   = 3'h5;
	localparam logic [2:0] MCR_SEL_STANDBY  = 3'h6;
	localparam logic [2:0] MCR_SEL_STOP     = 3'h4;
	localparam logic [2:0] MCR_SEL_SLEEP    = 3'h3;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and values after reset.
	localparam int         TIM_PER_LSB      = 0;
	localparam int         TIM_WIN_BIT      = 2;
	localparam int         LPC_WD_STOP_BIT  = 0;
	localparam logic [3:0] TIM_RESET_VAL    = 4'h4;
	localparam logic [3:0] LPC_RESET_VAL    = 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Clock period and millisecond in nanoseconds, the derived millisecond divider count, and times in milliseconds.
	localparam int         CLK_PERIOD_NS    = 10;
	localparam int         MS_NS            = 1000000;
	localparam int         MS_CYC_DEF       = MS_NS / CLK_PERIOD_NS;
	localparam int         MS_W             = 9;
	localparam logic [8:0] NREQ_MS          = 9'd350;
	localparam logic [8:0] RST_DUR_MS       = 9'd10;
	localparam logic [8:0] WD_PER0_MS       = 9'd10;
	localparam logic [8:0] WD_PER1_MS       = 9'd45;
	localparam logic [8:0] WD_PER2_MS       = 9'd100;
	localparam logic [8:0] WD_PER3_MS       = 9'd350;

	////////////////////////////////////////////////////////////////////////////////
	// Operating modes and command port carrier.
	typedef enum {
		st_reset,
		st_normal_req,
		st_normal,
		st_standby,
		st_stop,
		st_sleep
	} mode_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [3:0] data;
	} bus_req_s;

endpackage

// ===== logic/ms_tick.sv
// Millisecond enable pulse divider.
module ms_tick #(
	parameter int CYC = 100000
) (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic sys_rst_i,
	// Enable pulse
	output logic      tick_o
);

	logic [31:0] cnt_q;

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			cnt_q  <= 32'h0;
			tick_o <= 1'b0;
		end
		else if (cnt_q == 32'(CYC - 1))
		begin
			cnt_q  <= 32'h0;
			tick_o <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + 32'h1;
			tick_o <= 1'b0;
		end
	end

endmodule

// ===== logic/sbc_debug_mode_watchdog_ctrl.sv
// Mode sequencing, debug entry and window watchdog of the basis chip control port.
//
// Functional notes
// - Unconfigured after power-up, reset is asserted again every 360 ms.
// - Unconfigured loop: reset low for reset duration, then released 350 ms.
// - Power-up sets battery-fail flag; device then goes to normal-request mode.
// - Timing write in normal-request mode moves device to normal mode.
// - Mode-control write 0000 in normal mode with battery-fail set enables debug.
// - With debug enabled, mode-control write x101 selects normal debug mode.
// - In debug no watchdog clearing needed and no watchdog reset generated.
// - Mode-control write 0000 while in debug leaves debug mode.
// - Timing, enable and select must finish inside 350 ms, else reset.
// - Wake-up from stop or sleep in debug gives 350 ms normal-request.
// - Stop entered from debug runs without watchdog, ignoring stop bit.
// - Outside debug, clearing in the closed window half of normal or standby causes a reset.
// - After watchdog timeout the fault output stays low until timing write.
module sbc_debug_mode_watchdog_ctrl #(
	parameter int ms_cyc = sbc_pkg::MS_CYC_DEF
) (
	// Clock and reset
	input  wire logic             clock_i,
	input  wire logic             sys_rst_i,
	// Command port
	input  wire sbc_pkg::bus_req_s bus_req_i,
	output logic [7:0]            rd_data_o,
	// Wake-up event from stop or sleep
	input  wire logic             wake_i,
	// Device outputs
	output logic                  rst_n_o,
	output logic                  wd_fault_n_o,
	output logic                  debug_active_o
);
	import sbc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	mode_e            state_q;
	mode_e            state_d;
	logic             ms_tick_w;
	logic [MS_W-1:0]  tm_q;
	logic [MS_W-1:0]  wd_ms_q;
	logic [3:0]       watchdog_timing_subreg_q;
	logic [3:0]       low_power_q;
	logic             batfail_q;
	logic             debug_active_q;
	logic             wd_timeout_q;
	logic             tm_expire;
	logic             wd_expire;
	logic             wd_closed;
	logic             wd_running;
	logic             tim_wr;
	logic             mcr_wr;
	logic             mcr_rd;
	logic             mcr_zero;
	logic             wd_bad_clear;

	function automatic logic [MS_W-1:0] wd_period(input logic [1:0] sel);
		case (sel)
			2'h0:    wd_period = WD_PER0_MS;
			2'h1:    wd_period = WD_PER1_MS;
			2'h2:    wd_period = WD_PER2_MS;
			default: wd_period = WD_PER3_MS;
		endcase
	endfunction

	ms_tick #(
		.CYC     (ms_cyc)
	) u_ms_tick (
		.clock_i (clock_i),
		.sys_rst_i(sys_rst_i),
		.tick_o  (ms_tick_w)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Command decode.
	always_comb
	begin
		tim_wr = bus_req_i.wr && (bus_req_i.addr == ADDR_WD_TIMING);
		mcr_wr = bus_req_i.wr && (bus_req_i.addr == ADDR_MODE_CTRL);
		mcr_rd = bus_req_i.rd && (bus_req_i.addr == ADDR_MODE_CTRL);
		mcr_zero = mcr_wr && (bus_req_i.data == MCR_DEBUG_TOGGLE);
	end

	// The watchdog is suspended whenever debug is active, and in stop unless the stop bit asks for it.
	always_comb
	begin
		tm_expire  = ms_tick_w && (tm_q <= 9'd1);
		wd_running = !debug_active_q && ((state_q == st_normal) || (state_q == st_standby)
			|| ((state_q == st_stop) && low_power_q[LPC_WD_STOP_BIT]));
		wd_expire  = wd_running && ms_tick_w
			&& (wd_ms_q >= wd_period(watchdog_timing_subreg_q[TIM_PER_LSB +: 2]) - 9'd1);
		wd_closed  = watchdog_timing_subreg_q[TIM_WIN_BIT]
			&& (wd_ms_q < (wd_period(watchdog_timing_subreg_q[TIM_PER_LSB +: 2]) >> 1));
		wd_bad_clear = tim_wr && wd_running && (state_q != st_stop) && wd_closed;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode sequencing.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			st_reset:
			begin
				if (tm_expire)
					state_d = st_normal_req;
			end
			st_normal_req:
			begin
				if (tim_wr)
					state_d = st_normal;
				else if (debug_active_q && mcr_wr && (bus_req_i.data[2:0] == MCR_SEL_NORMAL))
					state_d = st_normal;
				else if (debug_active_q && mcr_wr && (bus_req_i.data[2:0] == MCR_SEL_STANDBY))
					state_d = st_standby;
				else if (tm_expire)
					state_d = st_reset;
			end
			st_normal, st_standby:
			begin
				if (wd_expire || wd_bad_clear)
					state_d = st_reset;
				else if (batfail_q && (state_q == st_normal) && tm_expire)
					state_d = st_reset;
				else if (mcr_wr && !mcr_zero)
				begin
					if (bus_req_i.data[2:0] == MCR_SEL_NORMAL)
						state_d = st_normal;
					else if (bus_req_i.data[2:0] == MCR_SEL_STANDBY)
						state_d = st_standby;
					else if (bus_req_i.data[2:0] == MCR_SEL_STOP)
						state_d = st_stop;
					else if (bus_req_i.data[2:0] == MCR_SEL_SLEEP)
						state_d = st_sleep;
				end
			end
			st_stop:
			begin
				if (wake_i)
					state_d = st_normal_req;
				else if (wd_expire)
					state_d = st_reset;
			end
			default:
			begin
				if (wake_i)
					state_d = debug_active_q ? st_normal_req : st_reset;
			end
		endcase
	end

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			state_q <= st_reset;
		else
			state_q <= state_d;
	end

	// One timer serves the reset duration, the normal-request window and the debug entry window.
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			tm_q <= RST_DUR_MS;
		else if ((state_d == st_reset) && (state_q != st_reset))
			tm_q <= RST_DUR_MS;
		else if ((state_d == st_normal_req) && (state_q != st_normal_req))
			tm_q <= NREQ_MS;
		else if (ms_tick_w && (tm_q != 9'd0))
			tm_q <= tm_q - 9'd1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog counter.
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			wd_ms_q <= 9'd0;
		else if (!wd_running || tim_wr || (state_d != state_q))
			wd_ms_q <= 9'd0;
		else if (ms_tick_w)
			wd_ms_q <= wd_ms_q + 9'd1;
	end

	// A fresh timeout wins over a proper timing write in the same cycle.
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			wd_timeout_q <= 1'b0;
		else if (wd_expire || wd_bad_clear)
			wd_timeout_q <= 1'b1;
		else if (tim_wr)
			wd_timeout_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags and configuration registers.
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			batfail_q <= 1'b1;
		else if (mcr_rd)
			batfail_q <= 1'b0;
		else if (debug_active_q && mcr_wr && (bus_req_i.data[2:0] == MCR_SEL_NORMAL))
			batfail_q <= 1'b0;
	end

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			debug_active_q <= 1'b0;
		else if (mcr_zero && debug_active_q)
			debug_active_q <= 1'b0;
		else if (mcr_zero && batfail_q && (state_q == st_normal))
			debug_active_q <= 1'b1;
	end

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			watchdog_timing_subreg_q <= TIM_RESET_VAL;
		else if (tim_wr)
			watchdog_timing_subreg_q <= bus_req_i.data;
	end

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			low_power_q <= LPC_RESET_VAL;
		else if (bus_req_i.wr && (bus_req_i.addr == ADDR_LOW_POWER))
			low_power_q <= bus_req_i.data;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, valid only in the cycle after the read strobe.
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			rd_data_o <= 8'h00;
		else if (!bus_req_i.rd)
			rd_data_o <= 8'h00;
		else if (bus_req_i.addr == ADDR_MODE_CTRL)
			rd_data_o <= {4'h0, debug_active_q, batfail_q, wd_timeout_q, 1'b0};
		else if (bus_req_i.addr == ADDR_WD_TIMING)
			rd_data_o <= {4'h0, watchdog_timing_subreg_q};
		else if (bus_req_i.addr == ADDR_LOW_POWER)
			rd_data_o <= {4'h0, low_power_q};
		else if (bus_req_i.addr == ADDR_STATUS)
			rd_data_o <= {5'h00, 3'(state_q)};
		else
			rd_data_o <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output pins, registered from the next state so they track the mode without lag.
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			rst_n_o        <= 1'b0;
			wd_fault_n_o   <= 1'b1;
			debug_active_o <= 1'b0;
		end
		else
		begin
			rst_n_o        <= (state_d != st_reset) && (state_d != st_sleep);
			wd_fault_n_o   <= !((wd_expire || wd_bad_clear) || (wd_timeout_q && !tim_wr));
			debug_active_o <= !(mcr_zero && debug_active_q)
				&& (debug_active_q || (mcr_zero && batfail_q && (state_q == st_normal)));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.
	sequence s_nreq_timeout;
		(state_q == st_normal_req) && !tim_wr && !mcr_wr && tm_expire;
	endsequence

	sequence s_select_normal_debug;
		debug_active_q && mcr_wr && (bus_req_i.data[2:0] == MCR_SEL_NORMAL) && !wd_expire && !wd_bad_clear
			&& ((state_q == st_normal) || (state_q == st_standby) || (state_q == st_normal_req))
			&& !((state_q == st_normal) && batfail_q && tm_expire);
	endsequence

	sequence s_reset_done;
		(state_q == st_reset) && tm_expire;
	endsequence

	a_unconf_loop: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		s_nreq_timeout |=> (state_q == st_reset) && !rst_n_o)
		else $error("normal-request timeout did not enter reset");

	a_reset_release: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		s_reset_done |=> (state_q == st_normal_req) && rst_n_o && (tm_q == NREQ_MS))
		else $error("reset duration end did not release reset");

	a_batfail_nreq: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(s_reset_done ##0 (batfail_q && !mcr_rd)) |=> batfail_q && (state_q == st_normal_req))
		else $error("battery-fail flag lost or normal-request not entered");

	a_timing_normal: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		((state_q == st_normal_req) && tim_wr) |=> (state_q == st_normal))
		else $error("timing write did not enter normal mode");

	a_debug_enable: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(mcr_zero && batfail_q && !debug_active_q && (state_q == st_normal)) |=> debug_active_q && debug_active_o)
		else $error("debug enable write ignored");

	a_debug_select: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		s_select_normal_debug |=> (state_q == st_normal) && !batfail_q)
		else $error("normal debug not selected");

	a_no_wd_reset: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(debug_active_q && !wd_timeout_q && !mcr_zero) |=> !wd_timeout_q && wd_fault_n_o)
		else $error("watchdog fault raised in debug");

	a_debug_leave: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(mcr_zero && debug_active_q) |=> !debug_active_q && !debug_active_o)
		else $error("debug not left on 0000 write");

	a_seq_window: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		((state_q == st_normal) && batfail_q && tm_expire) |=> (state_q == st_reset))
		else $error("debug entry window expiry did not reset");

	a_wake_nreq: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(debug_active_q && wake_i && ((state_q == st_stop) || (state_q == st_sleep)))
		|=> (state_q == st_normal_req) && (tm_q == NREQ_MS))
		else $error("debug wake-up did not give normal-request window");

	a_stop_no_wd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		((state_q == st_stop) && debug_active_q && !wake_i) |=> (state_q == st_stop) && (wd_ms_q == 9'd0))
		else $error("watchdog ran in debug stop");

	a_closed_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		((state_q == st_normal) && !debug_active_q && tim_wr && wd_closed) |=> (state_q == st_reset) && wd_timeout_q)
		else $error("closed window clear did not reset");

	a_fault_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(wd_timeout_q && !tim_wr) |=> wd_timeout_q && !wd_fault_n_o)
		else $error("watchdog fault released without timing write");

endmodule

// ===== dv/sbc_host_model.sv
// Host microcontroller model that drives the command port and watches the reset output.
module sbc_host_model (
	// Clock and reset output of the device
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	// Command port
	output sbc_pkg::bus_req_s bus_req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import sbc_pkg::*;

	initial bus_req_o = '0;

	////////////////////////////////////////////////////////////////////////////////
	// One-cycle command launched after an edge; the short delay lets the edge's updates land.
	task automatic cmd(input logic w, input logic [3:0] a, input logic [3:0] d);
		@(posedge clock_i);
		bus_req_o <= '{wr: w, rd: !w, addr: a, data: d};
		@(posedge clock_i);
		bus_req_o <= '0;
		#1;
	endtask

	// The three writes go back to back so the request window cannot run out.
	task automatic enter_debug(input logic [3:0] tim, input logic b3);
		cmd(1'b1, ADDR_WD_TIMING, tim);
		cmd(1'b1, ADDR_MODE_CTRL, MCR_DEBUG_TOGGLE);
		cmd(1'b1, ADDR_MODE_CTRL, {b3, MCR_SEL_NORMAL});
	endtask

	// Reading the battery-fail flag first keeps the later 0000 write from enabling debug.
	task automatic refuse_debug();
		cmd(1'b0, ADDR_MODE_CTRL, 4'h0);
		for (int i = 0; i < 300 && rst_n_i !== 1'b1; i++)
			@(posedge clock_i);
		cmd(1'b1, ADDR_WD_TIMING, 4'h4);
		cmd(1'b1, ADDR_MODE_CTRL, MCR_DEBUG_TOGGLE);
	endtask
endmodule

// ===== dv/sbc_debug_mode_watchdog_ctrl_tb_top.sv
// Self-checking bench for the mode and watchdog controller with a host model.
module sbc_debug_mode_watchdog_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sbc_pkg::*;

	localparam int MS = 10;
	logic       clock_i;
	logic       sys_rst_i;
	logic       wake_i;
	logic       rst_n_o;
	logic       wd_fault_n_o;
	logic       debug_active_o;
	logic       b3;
	logic       rd_seen;
	logic [7:0] rd_data_o;
	logic [7:0] exp_q[$];
	bus_req_s   bus_req;
	int         n_mismatch;
	int         compares;
	int         n;

	sbc_debug_mode_watchdog_ctrl #(.ms_cyc(MS)) i_dut (
		.clock_i        (clock_i),
		.sys_rst_i      (sys_rst_i),
		.bus_req_i      (bus_req),
		.rd_data_o      (rd_data_o),
		.wake_i         (wake_i),
		.rst_n_o        (rst_n_o),
		.wd_fault_n_o   (wd_fault_n_o),
		.debug_active_o (debug_active_o)
	);

	sbc_host_model i_host (
		.clock_i   (clock_i),
		.rst_n_i   (rst_n_o),
		.bus_req_o (bus_req)
	);

	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// The read answer stands one cycle only, so the monitor looks in exactly that cycle.
	always @(posedge clock_i)
	begin
		if (rd_seen)
			chk(rd_data_o, exp_q.pop_front());
		rd_seen = bus_req.rd;
	end

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.cmd(1'b0, a, 4'h0);
	endtask

	task automatic lvl(input logic v, input int max, output int cnt);
		cnt = 0;
		while (rst_n_o !== v && cnt < max)
		begin
			@(posedge clock_i);
			#1;
			cnt++;
		end
	endtask

	// Wake is sampled at the second edge, so the pulse is exactly one cycle wide.
	task automatic wake_pulse();
		@(posedge clock_i);
		wake_i <= 1'b1;
		@(posedge clock_i);
		wake_i <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (40000) @(posedge clock_i);
		n_mismatch++;
		summarize();
	end

	initial
	begin
		sys_rst_i = 1'b1;
		wake_i = 1'b0;
		rd_seen = 1'b0;
		n_mismatch = 0;
		compares = 0;
		n = $urandom(32'h30de4a1d);
		b3 = 1'($urandom);
		repeat (6) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		chk(rst_n_o, 1'b0);
		lvl(1'b1, 300, n);
		chk(n >= 85 && n <= 115, 1'b1);
		rd_chk(ADDR_STATUS, 8'h01);
		rd_chk(4'h7, 8'h00);
		lvl(1'b0, 4000, n);
		chk(n >= 3465 && n <= 3520, 1'b1);
		chk(wd_fault_n_o, 1'b1);
		lvl(1'b1, 300, n);
		chk(n >= 85 && n <= 115, 1'b1);
		// Enabling debug without selecting it leaves the request window running out.
		i_host.cmd(1'b1, ADDR_WD_TIMING, 4'h4);
		i_host.cmd(1'b1, ADDR_MODE_CTRL, MCR_DEBUG_TOGGLE);
		chk(debug_active_o, 1'b1);
		lvl(1'b0, 4000, n);
		chk(n >= 3465 && n <= 3520, 1'b1);
		chk(wd_fault_n_o, 1'b1);
		lvl(1'b1, 300, n);
		chk(n >= 85 && n <= 115, 1'b1);
		i_host.cmd(1'b1, ADDR_MODE_CTRL, MCR_DEBUG_TOGGLE);
		chk(debug_active_o, 1'b0);
		i_host.enter_debug(4'h4, b3);
		chk(debug_active_o, 1'b1);
		rd_chk(ADDR_MODE_CTRL, 8'h08);
		rd_chk(ADDR_STATUS, 8'h02);
		lvl(1'b0, 4000, n);
		chk(n == 4000, 1'b1);
		i_host.cmd(1'b1, ADDR_LOW_POWER, 4'h1);
		i_host.cmd(1'b1, ADDR_MODE_CTRL, {b3, MCR_SEL_STOP});
		rd_chk(ADDR_STATUS, 8'h04);
		lvl(1'b0, 4000, n);
		chk(n == 4000, 1'b1);
		wake_pulse();
		rd_chk(ADDR_STATUS, 8'h01);
		i_host.cmd(1'b1, ADDR_MODE_CTRL, {~b3, MCR_SEL_NORMAL});
		rd_chk(ADDR_STATUS, 8'h02);
		i_host.cmd(1'b1, ADDR_MODE_CTRL, {b3, MCR_SEL_SLEEP});
		chk(rst_n_o, 1'b0);
		rd_chk(ADDR_STATUS, 8'h05);
		wake_pulse();
		i_host.cmd(1'b1, ADDR_MODE_CTRL, {~b3, MCR_SEL_STANDBY});
		chk(rst_n_o, 1'b1);
		rd_chk(ADDR_STATUS, 8'h03);
		i_host.cmd(1'b1, ADDR_MODE_CTRL, {b3, MCR_SEL_NORMAL});
		i_host.cmd(1'b1, ADDR_MODE_CTRL, MCR_DEBUG_TOGGLE);
		chk(debug_active_o, 1'b0);
		lvl(1'b0, 400, n);
		chk(n < 400, 1'b1);
		chk(wd_fault_n_o, 1'b0);
		rd_chk(ADDR_MODE_CTRL, 8'h02);
		lvl(1'b1, 300, n);
		chk(wd_fault_n_o, 1'b0);
		i_host.cmd(1'b1, ADDR_WD_TIMING, 4'h4);
		chk(wd_fault_n_o, 1'b1);
		rd_chk(ADDR_STATUS, 8'h02);
		// A clear this soon falls in the closed first half of the period.
		i_host.cmd(1'b1, ADDR_WD_TIMING, 4'h4);
		lvl(1'b0, 5, n);
		chk(n < 5, 1'b1);
		chk(wd_fault_n_o, 1'b0);
		lvl(1'b1, 300, n);
		i_host.cmd(1'b1, ADDR_WD_TIMING, 4'h4);
		repeat (70) @(posedge clock_i);
		i_host.cmd(1'b1, ADDR_WD_TIMING, 4'h4);
		lvl(1'b0, 30, n);
		chk(n == 30, 1'b1);
		@(posedge clock_i);
		sys_rst_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		chk(rst_n_o, 1'b0);
		exp_q.push_back(8'h04);
		i_host.refuse_debug();
		chk(debug_active_o, 1'b0);
		rd_chk(ADDR_STATUS, 8'h02);
		repeat (3) @(posedge clock_i);
		summarize();
	end
endmodule
